// file: rtl/coef_addr_map.v
`include "coef_bank_consts.vh"

// ============================================================
// Page and offset to bank and byte index
module coef_addr_map (
    input  wire [7:0]  i_page,
    input  wire [6:0]  i_offset,
    output reg         o_hit_a,
    output reg         o_hit_b,
    output reg  [10:0] o_index
);
    reg [7:0] rel_page;

    always @*
    begin
        rel_page = 8'h00;
        o_hit_a  = 1'b0;
        o_hit_b  = 1'b0;
        if (i_offset >= `CB_OFF_COEF_FIRST)
        begin
            if (i_page >= `CB_PAGE_A_LOW && i_page <= `CB_PAGE_A_HIGH_HI)
            begin
                o_hit_a  = 1'b1; // RULE3 RULE4
                rel_page = i_page - `CB_PAGE_A_LOW;
            end
            else if (i_page >= `CB_PAGE_B_LO && i_page <= `CB_PAGE_B_HI)
            begin
                o_hit_b  = 1'b1; // RULE5
                rel_page = i_page - `CB_PAGE_B_LO;
            end
        end
        // Bytes run on across page ends, so each bank is one flat byte array
        o_index = rel_page[3:0] * `CB_BYTES_PER_PAGE
                + {4'h0, i_offset - `CB_OFF_COEF_FIRST}; // RULE11
    end
endmodule // coef_addr_map

// file: rtl/coef_bank_access.v
`include "coef_bank_consts.vh"

// ============================================================
// Paged register window onto the ADC filter coefficient buffers
module coef_bank_access #(
    parameter BANK_BYTES = `CB_BANK_BYTES,
    parameter ADDR_W     = `CB_BANK_ADDR_W
) (
    input  wire              i_clk,
    input  wire              i_resetn,
    input  wire [6:0]        i_addr,
    input  wire [7:0]        i_wdata,
    input  wire              i_wr,
    input  wire              i_rd,
    output wire [7:0]        o_rdata,
    input  wire              i_adc_powered_down,
    input  wire              i_frame_boundary,
    input  wire [ADDR_W-1:0] i_filt_addr,
    output wire [7:0]        o_filt_data,
    output wire              o_filter_bank,
    output wire [7:0]        o_page,
    output wire              o_adaptive_enable,
    output wire              o_active_bank,
    output wire              o_swap_pending
);

    // ============================================================
    // Reset release
    reg rst_meta_q;
    reg rst_sync_q;

    always @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    wire rst_n;
    assign rst_n = rst_sync_q;

    // ============================================================
    // Helpers
    function is_reserved;
        input [6:0] off;
        begin
            is_reserved = (off > `CB_OFF_PAGE_SEL) && (off < `CB_OFF_COEF_FIRST);
        end
    endfunction

    function is_cfg;
        input [7:0] page;
        input [6:0] off;
        begin
            is_cfg = (page == `CB_PAGE_A_LOW) && (off == `CB_OFF_ADAPT_CFG);
        end
    endfunction

    // ============================================================
    // State
    reg  [7:0] page_q;
    reg  [7:0] page_d;
    reg        adapt_en_q;
    reg        adapt_en_d;
    reg        active_bank_q;
    reg        active_bank_d;
    reg        swap_req_q;
    reg        swap_req_d;
    reg  [7:0] rdata_q;
    reg  [7:0] rdata_d;
    reg  [7:0] filt_data_q;
    reg  [7:0] filt_data_d;

    // ============================================================
    // Address map
    wire              map_hit_a;
    wire              map_hit_b;
    wire [10:0]       map_index;
    wire [ADDR_W-1:0] host_index;

    coef_addr_map u_map (
        .i_page   (page_q),
        .i_offset (i_addr),
        .o_hit_a  (map_hit_a),
        .o_hit_b  (map_hit_b),
        .o_index  (map_index)
    );

    assign host_index = map_index[ADDR_W-1:0];

    // ============================================================
    // Access gate
    // Adaptive on: host reaches only the buffer the filter is not using.
    // Adaptive off: both buffers open, but only with the ADC powered down,
    // since the filter may be reading them at any cycle otherwise.
    wire acc_a;
    wire acc_b;
    wire swap_now;
    wire cfg_wr;

    assign acc_a = map_hit_a & (adapt_en_q ? active_bank_q : i_adc_powered_down); // RULE6 RULE9
    assign acc_b = map_hit_b & (adapt_en_q ? ~active_bank_q : i_adc_powered_down); // RULE6 RULE9

    assign cfg_wr   = i_wr & is_cfg(page_q, i_addr);
    assign swap_now = adapt_en_q & swap_req_q & i_frame_boundary; // RULE10

    // ============================================================
    // Coefficient buffers
    wire [1:0]  bank_wr;
    wire [15:0] bank_host_data;
    wire [15:0] bank_filt_data;

    assign bank_wr[0] = i_wr & acc_a;
    assign bank_wr[1] = i_wr & acc_b;

    genvar b;
    generate
        for (b = 0; b < 2; b = b + 1)
        begin : g_bank
            coef_byte_ram #(
                .DEPTH  (BANK_BYTES),
                .ADDR_W (ADDR_W)
            ) u_ram (
                .i_clk       (i_clk),
                .i_wr_en     (bank_wr[b]),
                .i_host_addr (host_index),
                .i_wr_data   (i_wdata),
                .o_host_data (bank_host_data[b*8 +: 8]),
                .i_filt_addr (i_filt_addr),
                .o_filt_data (bank_filt_data[b*8 +: 8])
            );
        end
    endgenerate

    // ============================================================
    // Page select
    always @*
    begin
        page_d = page_q;
        if (i_wr && i_addr == `CB_OFF_PAGE_SEL)
        begin
            page_d = i_wdata; // RULE1 RULE2
        end
    end

    // ============================================================
    // Adaptive configuration
    always @*
    begin
        adapt_en_d    = adapt_en_q;
        active_bank_d = active_bank_q;
        swap_req_d    = swap_req_q;
        if (swap_now)
        begin
            active_bank_d = ~active_bank_q; // RULE9
            swap_req_d    = 1'b0; // RULE10
        end
        // A request written in the swap cycle stays pending: set wins
        if (cfg_wr)
        begin
            adapt_en_d = i_wdata[`CB_BIT_ADAPT_EN]; // RULE8
            if (i_wdata[`CB_BIT_SWAP_REQ])
            begin
                swap_req_d = 1'b1; // RULE10
            end
            else if (!swap_now)
            begin
                swap_req_d = 1'b0;
            end
        end
    end

    // ============================================================
    // Read data
    always @*
    begin
        rdata_d = 8'h00;
        if (i_rd)
        begin
            if (i_addr == `CB_OFF_PAGE_SEL)
            begin
                rdata_d = page_q; // RULE1
            end
            else if (is_cfg(page_q, i_addr))
            begin
                rdata_d = {5'h00, adapt_en_q, active_bank_q, swap_req_q}; // RULE8 RULE9
            end
            else if (is_reserved(i_addr))
            begin
                rdata_d = `CB_RSVD_VALUE; // RULE7
            end
            else if (acc_a)
            begin
                rdata_d = bank_host_data[7:0]; // RULE3 RULE4
            end
            else if (acc_b)
            begin
                rdata_d = bank_host_data[15:8]; // RULE5
            end
        end
    end

    // ============================================================
    // Filter side
    // Outside adaptive mode the filter always runs from buffer A
    wire filt_bank;

    assign filt_bank = adapt_en_q & active_bank_q;

    always @*
    begin
        filt_data_d = filt_bank ? bank_filt_data[15:8] : bank_filt_data[7:0];
    end

    // ============================================================
    // Registers
    always @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            page_q        <= `CB_PAGE_SEL_RESET;
            adapt_en_q    <= 1'b0;
            active_bank_q <= 1'b0;
            swap_req_q    <= 1'b0;
            rdata_q       <= 8'h00;
            filt_data_q   <= 8'h00;
        end
        else
        begin
            page_q        <= page_d;
            adapt_en_q    <= adapt_en_d;
            active_bank_q <= active_bank_d;
            swap_req_q    <= swap_req_d;
            rdata_q       <= rdata_d;
            filt_data_q   <= filt_data_d;
        end
    end

    // ============================================================
    // Outputs
    assign o_rdata           = rdata_q;
    assign o_filt_data       = filt_data_q;
    assign o_filter_bank     = filt_bank;
    assign o_page            = page_q;
    assign o_adaptive_enable = adapt_en_q;
    assign o_active_bank     = active_bank_q;
    assign o_swap_pending    = swap_req_q;

endmodule // coef_bank_access

// file: rtl/coef_bank_consts.vh
// Contract
// RULE1: Offset 0 is a read/write page-select byte, reset zero, choosing the next page.
// RULE2: The page-select byte answers at offset 0 of every coefficient page.
// RULE3: Page 8 offsets 8-127 hold read/write bytes of bank A coefficients 0-29.
// RULE4: Pages 9-16 offsets 8-127 continue bank A with coefficients 30-255.
// RULE5: Pages 26-34 offsets 8-127 hold bank B coefficients 0-255, read/write.
// RULE6: Adaptive off: coefficient access only while ADC is powered down.
// RULE7: Offsets 1-7 of coefficient pages are reserved, read zero; host writes zero.
// RULE8: Page 8 offset 1 bit 2 enables adaptive filtering; resets to zero.
// RULE9: Read-only flag: zero means filter uses A, host reaches B; one reverses.
// RULE10: Writing one to swap bit exchanges banks at next frame; self clears.
// RULE11: Coefficients fill consecutive bytes, most significant byte first.
`ifndef COEF_BANK_CONSTS_VH
`define COEF_BANK_CONSTS_VH

// ============================================================
// Page numbers
`define CB_PAGE_A_LOW       8'h08
`define CB_PAGE_A_HIGH_LO   8'h09
`define CB_PAGE_A_HIGH_HI   8'h10
`define CB_PAGE_B_LO        8'h1a
`define CB_PAGE_B_HI        8'h22

// ============================================================
// Offsets within a page
`define CB_OFF_PAGE_SEL     7'h00
`define CB_OFF_ADAPT_CFG    7'h01
`define CB_OFF_COEF_FIRST   7'h08
`define CB_OFF_COEF_LAST    7'h7f

// ============================================================
// Adaptive configuration fields and reset values
`define CB_BIT_ADAPT_EN     2
`define CB_BIT_ACTIVE_BANK  1
`define CB_BIT_SWAP_REQ     0
`define CB_PAGE_SEL_RESET   8'h00
`define CB_RSVD_VALUE       8'h00

// ============================================================
// Bank geometry
`define CB_BYTES_PER_PAGE   11'd120
`define CB_BANK_BYTES       1080
`define CB_BANK_ADDR_W      11

`endif

// file: rtl/coef_byte_ram.v
// ============================================================
// One coefficient buffer: host read/write port, filter read port
module coef_byte_ram #(
    parameter DEPTH  = 1080,
    parameter ADDR_W = 11
) (
    input  wire              i_clk,
    input  wire              i_wr_en,
    input  wire [ADDR_W-1:0] i_host_addr,
    input  wire [7:0]        i_wr_data,
    output wire [7:0]        o_host_data,
    input  wire [ADDR_W-1:0] i_filt_addr,
    output wire [7:0]        o_filt_data
);
    // No reset: contents are undefined until software loads them
    reg [7:0] mem [0:DEPTH-1];

    always @(posedge i_clk)
    begin
        if (i_wr_en)
        begin
            mem[i_host_addr] <= i_wr_data;
        end
    end

    assign o_host_data = mem[i_host_addr];
    assign o_filt_data = mem[i_filt_addr];
endmodule // coef_byte_ram

// file: verif/coef_bank_access_asserts.sv
// ==========================================
// Port checker for the coefficient window
module coef_bank_access_asserts (
    input wire       i_clk,
    input wire       i_resetn,
    input wire [6:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    input wire       i_rd,
    input wire [7:0] o_rdata,
    input wire       i_adc_powered_down,
    input wire       i_frame_boundary,
    input wire       o_filter_bank,
    input wire [7:0] o_page,
    input wire       o_adaptive_enable,
    input wire       o_active_bank,
    input wire       o_swap_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    wire cfg = (o_page == 8'h08) && (i_addr == 7'h01);
    wire swp = o_adaptive_enable && o_swap_pending && i_frame_boundary;
    a_page_write_load: assert property (
        i_wr && i_addr == 7'h00 |=> o_page == $past(i_wdata))
        else $error("page select not loaded");
    a_page_hold: assert property (
        !(i_wr && i_addr == 7'h00) |=> $stable(o_page))
        else $error("page select changed");
    a_page_read_any: assert property (
        i_rd && i_addr == 7'h00 |=> o_rdata == $past(o_page))
        else $error("page select read wrong");
    a_rsvd_read_zero: assert property (
        i_rd && i_addr inside {[1:7]} && !cfg |=> o_rdata == 8'h00)
        else $error("reserved read not zero");
    a_cfg_read_back: assert property (
        i_rd && cfg |=> o_rdata == {5'h00, $past(o_adaptive_enable),
        $past(o_active_bank), $past(o_swap_pending)})
        else $error("config read wrong");
    a_enable_write: assert property (
        i_wr && cfg |=> o_adaptive_enable == $past(i_wdata[2]))
        else $error("enable not written");
    a_gated_read_zero: assert property (
        i_rd && i_addr >= 7'h08 && !o_adaptive_enable && !i_adc_powered_down
        |=> o_rdata == 8'h00)
        else $error("gated coefficient read not zero");
    a_swap_at_frame: assert property (
        swp && !i_wr |=> o_active_bank != $past(o_active_bank) && !o_swap_pending)
        else $error("bank swap missed");
    a_swap_set_wins: assert property (
        swp && i_wr && cfg && i_wdata[0] |=> o_active_bank != $past(o_active_bank)
        && o_swap_pending)
        else $error("swap request written at swap lost");
    a_bank_hold: assert property (
        !swp && !i_wr |=> $stable(o_active_bank))
        else $error("active bank changed");
    a_swap_wait_off: assert property (
        !o_adaptive_enable && !i_wr |=> $stable(o_swap_pending))
        else $error("swap request lost");
    a_filter_bank_sel: assert property (
        o_filter_bank == (o_adaptive_enable && o_active_bank))
        else $error("filter bank wrong");
endmodule // coef_bank_access_asserts

bind coef_bank_access coef_bank_access_asserts i_coef_bank_access_asserts (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_adc_powered_down(i_adc_powered_down),
    .i_frame_boundary(i_frame_boundary), .o_filter_bank(o_filter_bank), .o_page(o_page),
    .o_adaptive_enable(o_adaptive_enable), .o_active_bank(o_active_bank),
    .o_swap_pending(o_swap_pending)
);

// file: verif/coef_bank_access_tb.sv
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
// ==========================================
// Self-checking bench
module coef_bank_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, resetn, wr, rd, pdn, fb, fbank, aen, abank, swp;
    logic [6:0]  addr, o;
    logic [7:0]  wdata, rdata, fdata, page, p, v;
    logic [10:0] faddr;
    logic [7:0]  pa [40];
    logic [6:0]  oa [40];
    logic [7:0]  mem [int];
    int          bad_count, n_tests;
    coef_bank_access i_coef_bank_access (.i_clk(clk), .i_resetn(resetn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_adc_powered_down(pdn),
        .i_frame_boundary(fb), .i_filt_addr(faddr), .o_filt_data(fdata),
        .o_filter_bank(fbank), .o_page(page), .o_adaptive_enable(aen),
        .o_active_bank(abank), .o_swap_pending(swp));
    host_bus_model i_host_bus_model (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    function automatic int key(input logic [7:0] pg, input logic [6:0] of);
        return (pg >= 8'h1a ? 2048 + (int'(pg) - 26) * 120 : (int'(pg) - 8) * 120) + int'(of) - 8;
    endfunction
    task automatic w(input logic [6:0] a, input logic [7:0] d);
        i_host_bus_model.wr(a, d);
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        i_host_bus_model.rd(a, r);
        `CHK(r, e)
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200000;
        bad_count++;
        summarize();
    end
    initial
    begin
        resetn = 1'b0;
        pdn = 1'b1;
        fb = 1'b0;
        faddr = 11'h000;
        void'($urandom(32'hf2d1));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(page, 8'h00)
        for (int i = 0; i < 8; i++)
        begin
            p = $urandom;
            w(7'h00, p);
            rchk(7'h00, p);
        end
        for (int i = 0; i < 40; i++)
        begin
            p = (i % 2) ? 8'h1a + 8'($urandom % 9) : 8'h08 + 8'($urandom % 9);
            o = (i < 4) ? ((i > 1) ? 7'h7f : 7'h08) : 7'h08 + 7'($urandom % 120);
            v = $urandom;
            pa[i] = p;
            oa[i] = o;
            mem[key(p, o)] = v;
            w(7'h00, p);
            w(o, v);
        end
        for (int i = 0; i < 40; i++)
        begin
            w(7'h00, pa[i]);
            rchk(oa[i], mem[key(pa[i], oa[i])]);
        end
        for (int i = 0; i < 3; i++)
        begin
            w(7'h00, 8'h08);
            w(7'(8 + i), 8'h12 + 8'(8'h22 * i));
        end
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk) faddr <= 11'(i);
            @(posedge clk);
            #1 `CHK(fdata, 8'h12 + 8'(8'h22 * i))
        end
        w(7'h00, 8'h1a);
        w(7'h08, 8'h5a);
        pdn <= 1'b0;
        w(7'h08, 8'ha5);
        rchk(7'h08, 8'h00);
        @(posedge clk) pdn <= 1'b1;
        rchk(7'h08, 8'h5a);
        for (int i = 1; i < 8; i++)
        begin
            w(7'(i), 8'h00);
            rchk(7'(i), 8'h00);
        end
        @(posedge clk) pdn <= 1'b0;
        w(7'h00, 8'h08);
        rchk(7'h01, 8'h00);
        w(7'h01, 8'h04);
        rchk(7'h01, 8'h04);
        rchk(7'h08, 8'h00);
        w(7'h01, 8'h05);
        rchk(7'h01, 8'h05);
        @(posedge clk) fb <= 1'b1;
        @(posedge clk) fb <= 1'b0;
        #1 `CHK(abank, 1'b1)
        `CHK(fbank, 1'b1)
        rchk(7'h01, 8'h06);
        rchk(7'h08, 8'h12);
        w(7'h00, 8'h1a);
        rchk(7'h08, 8'h00);
        w(7'h00, 8'h08);
        w(7'h01, 8'h01);
        @(posedge clk) fb <= 1'b1;
        @(posedge clk) fb <= 1'b0;
        rchk(7'h01, 8'h03);
        `CHK(fbank, 1'b0)
        w(7'h01, 8'h05);
        // Request written in the very cycle of the swap must survive it
        fork
            w(7'h01, 8'h05);
            begin
                @(posedge clk) fb <= 1'b1;
                @(posedge clk) fb <= 1'b0;
            end
        join
        rchk(7'h01, 8'h05);
        w(7'h01, 8'h04);
        rchk(7'h01, 8'h04);
        @(posedge clk) fb <= 1'b1;
        @(posedge clk) fb <= 1'b0;
        #1 `CHK(abank, 1'b0)
        @(posedge clk) resetn <= 1'b0;
        @(posedge clk) resetn <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(page, 8'h00)
        `CHK(aen, 1'b0)
        summarize();
    end
endmodule // coef_bank_access_tb

// file: verif/host_bus_model.sv
// ==========================================
// Host side of the register port
module host_bus_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic      [6:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_addr = 7'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        // Released lines flip so stale values cannot look valid
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        // Data stand only in the cycle after the strobe
        @(negedge i_clk);
        d = i_rdata;
    endtask
endmodule // host_bus_model
